/* logic/basic_timer.sv */
/*
  Basic 8-bit timer with prescaler, rtc clock and overflow interrupt.
  Assumes the bus master keeps strobes one cycle and never both at once;
  the 32 kHz oscillator arrives asynchronously and is far slower than
  the instruction clock.
*/
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
module basic_timer
  import tmr_pkg::*;
(
  input  wire logic              sys_clk_in,
  input  wire logic              reset_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic      [DATA_W-1:0] rdata_out,
  input  wire logic              lo_osc_in,
  input  wire logic              internal_rc_with_rtc_in,
  input  wire logic              green_mode_in,
  output logic                   irq_out,
  output logic      [15:0]       irq_vector_out,
  output logic                   wake_out,
  output logic                   overflow_out
);
  tmr_state_s q;
  tmr_state_s d;
  reg_req_s   req;
  logic       tick;
  logic       ovf;
  logic       rtc_on;
  logic       lo_rise;

  // prescaler carry tap: rate 000 needs bits 7:0 all set (div 256), 111 bit 0 alone (div 2)
  // a part-select with a variable bound is illegal, so build a low mask
  function automatic logic pre_tap(input logic [2:0] rate,
                                   input logic [PRE_W-1:0] pre);
    logic [2:0]       idx;
    logic [PRE_W-1:0] mask;
    idx     = 3'(PRE_W - 1) - rate;
    mask    = PRE_W'((1 << (int'(idx) + 1)) - 1);
    pre_tap = ((pre & mask) == mask);
  endfunction : pre_tap

  assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

  always_comb begin
    rtc_on  = q.mode[BIT_RTC] & internal_rc_with_rtc_in;
    lo_rise = q.lo_sync[1] & ~q.lo_prev;
    if (rtc_on) begin
      tick = lo_rise && (q.rtc_div == 6'(RTC_DIV - 1));
    end else begin
      tick = pre_tap(q.mode[BIT_RATE_HI:BIT_RATE_LO], q.pre);
    end
    tick = tick & q.mode[BIT_RUN];
    ovf  = tick && (q.count == COUNT_FULL);
  end

  always_comb begin
    d         = q;
    d.lo_sync = {q.lo_sync[0], lo_osc_in};
    d.lo_prev = q.lo_sync[1];
    d.rdata   = RESET_VAL;
    // prescaler free-runs only while counting so the first interval is whole
    if (q.mode[BIT_RUN] && !rtc_on) begin
      d.pre = q.pre + 1'b1;
    end else begin
      d.pre = '0;
    end
    if (q.mode[BIT_RUN] && rtc_on) begin
      if (lo_rise) begin
        d.rtc_div = q.rtc_div + 1'b1;
      end
    end else begin
      d.rtc_div = '0;
    end
    if (tick) begin
      d.count = q.count + 1'b1;
    end
    if (req.rd) begin
      case (req.addr)
        ADDR_MODE: begin
          d.rdata = q.mode & MODE_MASK;
        end
        ADDR_COUNT: begin
          d.rdata = q.count;
        end
        ADDR_CTRL: begin
          d.rdata = {6'h00, q.irq_en, q.ovf_flag};
        end
        ADDR_STATUS: begin
          d.rdata     = {7'h00, q.ev_status};
          d.ev_status = 1'b0;
        end
        ADDR_MASK: begin
          d.rdata = {7'h00, q.ev_mask};
        end
        default: begin
          d.rdata = RESET_VAL;
        end
      endcase
    end
    if (req.wr) begin
      case (req.addr)
        ADDR_MODE: begin
          d.mode = req.wdata & MODE_MASK;
        end
        ADDR_COUNT: begin
          d.count = req.wdata;
        end
        ADDR_CTRL: begin
          d.ovf_flag = req.wdata[BIT_OVF];
          d.irq_en   = req.wdata[BIT_IEN];
        end
        ADDR_MASK: begin
          d.ev_mask = req.wdata[BIT_OVF];
        end
        default: begin
        end
      endcase
    end
    // hardware set wins over a software clear in the same cycle
    if (ovf) begin
      d.ovf_flag  = 1'b1;
      d.ev_status = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rdata_out      = q.rdata;
  assign irq_out        = (q.ovf_flag & q.irq_en) |
                          (q.ev_status & q.ev_mask);
  assign irq_vector_out = IRQ_VECTOR;
  assign wake_out       = green_mode_in & q.ev_status;
  assign overflow_out   = q.ev_status;
endmodule : basic_timer

/* logic/tmr_pkg.sv */
/*
  Constants, register map and state layout of the 8-bit basic timer.
  Assumes one 20 MHz instruction clock and a plain register port.
*/
package tmr_pkg;
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 8;
  localparam logic [7:0]  ADDR_MODE    = 8'hB2;
  localparam logic [7:0]  ADDR_COUNT   = 8'hB3;
  localparam logic [7:0]  ADDR_CTRL    = 8'hB4;
  localparam logic [7:0]  ADDR_STATUS  = 8'hB5;
  localparam logic [7:0]  ADDR_MASK    = 8'hB6;
  localparam int          BIT_RUN      = 7;
  localparam int          BIT_RATE_HI  = 6;
  localparam int          BIT_RATE_LO  = 4;
  localparam int          BIT_RTC      = 0;
  localparam int          BIT_OVF      = 0;
  localparam int          BIT_IEN      = 1;
  localparam logic [7:0]  MODE_MASK    = 8'hF1;
  localparam logic [7:0]  RESET_VAL    = 8'h00;
  localparam logic [7:0]  COUNT_FULL   = 8'hFF;
  localparam logic [15:0] IRQ_VECTOR   = 16'h000B;
  localparam int          RTC_DIV      = 64;
  localparam int          PRE_W        = 8;

  typedef struct packed {
    logic [7:0]       mode;
    logic [7:0]       count;
    logic             ovf_flag;
    logic             irq_en;
    logic             ev_status;
    logic             ev_mask;
    logic [PRE_W-1:0] pre;
    logic [5:0]       rtc_div;
    logic [1:0]       lo_sync;
    logic             lo_prev;
    logic [7:0]       rdata;
  } tmr_state_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_s;
endpackage : tmr_pkg

/* tb/basic_timer_sva.sv */
/* Port checker for basic_timer.
   Assumes one clock and the bind below. */
`timescale 1ns/1ps
module basic_timer_chk
  import tmr_pkg::*;
(
  input wire logic        sys_clk_in,
  input wire logic        reset_in,
  input wire logic [7:0]  addr_in,
  input wire logic        rd_in,
  input wire logic [7:0]  rdata_out,
  input wire logic        green_mode_in,
  input wire logic        irq_out,
  input wire logic [15:0] irq_vector_out,
  input wire logic        wake_out,
  input wire logic        overflow_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  property p_vec; irq_vector_out == IRQ_VECTOR; endproperty
  a_vec: assert property (p_vec) else $error("vector");
  property p_wake; wake_out == (green_mode_in && overflow_out); endproperty
  a_wake: assert property (p_wake) else $error("wake");
  property p_stick;
    overflow_out && !(rd_in && addr_in == ADDR_STATUS) |=> overflow_out;
  endproperty
  a_stick: assert property (p_stick) else $error("sticky");
  property p_srd;
    rd_in && addr_in == ADDR_STATUS |=> rdata_out[0] == $past(overflow_out);
  endproperty
  a_srd: assert property (p_srd) else $error("status read");
  property p_idle; !rd_in |=> rdata_out == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("idle data");
  property p_mrd; rd_in && addr_in == ADDR_MODE |=> rdata_out[3:1] == 3'h0;
  endproperty
  a_mrd: assert property (p_mrd) else $error("mode bits");
  property p_gap; rd_in && addr_in > ADDR_MASK |=> rdata_out == 8'h00;
  endproperty
  a_gap: assert property (p_gap) else $error("unmapped");
  property p_rst; $fell(reset_in) |-> !irq_out && !wake_out; endproperty
  a_rst: assert property (p_rst) else $error("reset");
endmodule : basic_timer_chk

bind basic_timer basic_timer_chk u_chk (.sys_clk_in, .reset_in, .addr_in,
  .rd_in, .rdata_out, .green_mode_in, .irq_out, .irq_vector_out,
  .wake_out, .overflow_out);

/* tb/basic_timer_tb.sv */
/* Self-checking bench for basic_timer.
   Assumes tmr_pkg and the checker are compiled first. */
`timescale 1ns/1ps
module basic_timer_tb
  import tmr_pkg::*;
;
  logic       clk = 0, rst = 1, wr = 0, rd = 0, lo = 0, rc = 1, grn = 0;
  logic [7:0] a = 0, d = 0, q;
  logic       irq, wake, ovf;
  int         n_errors = 0, n_checks = 0;
  always #25 clk = ~clk;
  // oscillator far slower than the system clock, period of 8 cycles
  always begin repeat (4) @(posedge clk); lo <= ~lo; end
  basic_timer dut (.sys_clk_in(clk), .reset_in(rst), .addr_in(a),
    .wdata_in(d), .wr_in(wr), .rd_in(rd), .rdata_out(q), .lo_osc_in(lo),
    .internal_rc_with_rtc_in(rc), .green_mode_in(grn), .irq_out(irq),
    .irq_vector_out(), .wake_out(wake), .overflow_out(ovf));
  task chk(input logic [7:0] s, e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task w(input logic [7:0] ad, dd);
    @(posedge clk);
    a <= ad; d <= dd; wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask : w
  task r(input logic [7:0] ad, e);
    @(posedge clk);
    a <= ad; rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 chk(q, e);
  endtask : r
  // window of n+2 run cycles from a cleared prescaler catches ticks 1..4, the 4th on its last edge
  task run(input logic [7:0] c, m, input int n, input logic [7:0] e);
    w(ADDR_COUNT, c);
    w(ADDR_MODE, m & 8'h7F);
    w(ADDR_MODE, m);
    repeat (n) @(posedge clk);
    w(ADDR_MODE, m & 8'h7F);
    r(ADDR_COUNT, e);
  endtask : run
  task summarize;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 6; i++) r(ADDR_MODE + i[7:0], 8'h00);
    w(8'hB7, 8'hFF);
    r(8'hB7, 8'h00);
    w(ADDR_MODE, 8'h7E);
    r(ADDR_MODE, 8'h70);
    w(ADDR_COUNT, 8'h5A);
    repeat (300) @(posedge clk);
    r(ADDR_COUNT, 8'h5A);
    for (int k = 0; k < 8; k++) begin
      run(8'h00, {1'b1, k[2:0], 4'h0}, (4 << (8 - k)) - 2, 8'h04);
    end
    grn <= 1;
    w(ADDR_CTRL, 8'h02);
    w(ADDR_MASK, 8'h01);
    run(8'hFE, 8'hF0, 6, 8'h02);
    chk(ovf, 8'h01);
    chk(wake, 8'h01);
    chk(irq, 8'h01);
    r(ADDR_STATUS, 8'h01);
    chk(ovf, 8'h00);
    r(ADDR_CTRL, 8'h03);
    w(ADDR_CTRL, 8'h00);
    #1 chk(irq, 8'h00);
    run(8'h00, 8'hF1, 1100, 8'h02);
    rc <= 0;
    run(8'h00, 8'hF1, 6, 8'h04);
    summarize();
  end
endmodule : basic_timer_tb
